// ### core/esp_pkg.sv
package esp_pkg;

  // field widths of the edge bus and the segment word
  localparam int DY_W    = 8;
  localparam int M_W     = 4;
  localparam int X_W     = 11;
  localparam int S_W     = 13;
  localparam int B_W     = 7;
  localparam int G_W     = 10;
  localparam int C_W     = 12;
  localparam int DB_W    = 8;
  localparam int R_W     = 10;
  localparam int N_W     = 4;
  localparam int NF_W    = 3;
  localparam int GO_W    = 10;
  localparam int FRAC    = 11;
  localparam int SCALE_W = DY_W + (1 << M_W) - 1;
  localparam int PX_W    = SCALE_W + 1 + S_W;
  localparam int PB_W    = SCALE_W + 1 + G_W;
  localparam int GP_W    = (DB_W - 1) + R_W;
  localparam int G_SHIFT = 7;

  // width limits, reciprocal constants, rounding
  localparam logic [X_W-1:0]  WIDTH_MIN     = 11'h002;
  localparam logic [X_W-1:0]  WIDTH_NARROW  = 11'h004;
  localparam logic [X_W-1:0]  WIDTH_MAX_RST = 11'h7FF;
  localparam logic [R_W-1:0]  R_SHADED      = 10'h200;
  localparam logic [N_W-1:0]  LZ_CAP        = 4'h9;
  localparam logic [NF_W-1:0] NF_CAP        = 3'h7;
  localparam logic [GP_W-1:0] G_HALF        = 17'h00040;
  localparam int ROUND_HALF = 1 << (FRAC - 1);

  // reciprocal table
  localparam int TBL_DEPTH = 256;
  localparam int TBL_W     = 11;
  localparam int TA_W      = 8;

  // segment buffer word counter
  localparam logic [8:0] BUF_WORDS = 9'h100;
  localparam logic [8:0] CNT_FIRST = 9'h001;

  // pipeline tick derived from the 134 ns pipe period
  localparam int CLK_PERIOD_NS = 25;
  localparam int PIPE_TICK_NS  = 134;
  localparam int TICK_CYCLES   =
    (PIPE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_CW = 3;
  localparam logic [TICK_CW-1:0] TICK_LAST = TICK_CW'(TICK_CYCLES - 1);

  // register port
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] ADDR_WIDTH_MAX = 8'h00;
  localparam logic [REG_AW-1:0] ADDR_STATUS    = 8'h04;

  typedef struct packed {
    logic                  v;
    logic [DY_W-1:0]       dy;
    logic [M_W-1:0]        m;
    logic [X_W-1:0]        x;
    logic signed [S_W-1:0] s;
    logic [B_W-1:0]        b;
    logic signed [G_W-1:0] g;
    logic [C_W-1:0]        c;
    logic                  f;
  } esp_edge_t;

  typedef struct packed {
    logic                  v;
    logic [C_W-1:0]        c;
    logic                  f;
    logic [X_W-1:0]        x;
    logic [B_W-1:0]        b;
    logic signed [S_W-1:0] s;
    logic signed [G_W-1:0] g;
    logic [SCALE_W-1:0]    scale;
  } esp_lvl1_t;

  typedef struct packed {
    logic                   v;
    logic [C_W-1:0]         c;
    logic                   f;
    logic [X_W-1:0]         x;
    logic [B_W-1:0]         b;
    logic signed [PX_W-1:0] px;
    logic signed [PB_W-1:0] pb;
  } esp_lvl2_t;

  typedef struct packed {
    logic           v;
    logic [C_W-1:0] c;
    logic           f;
    logic [X_W-1:0] x;
    logic [B_W-1:0] b;
  } esp_icpt_t;

  typedef struct packed {
    logic            v;
    logic            valid_and_more_follow;
    logic [X_W:0]    dx;
    logic [DB_W-1:0] db;
    logic            f;
    logic [C_W-1:0]  c;
  } esp_seg5_t;

  typedef struct packed {
    logic            v;
    logic            valid_and_more_follow;
    logic            width_under_four;
    logic [X_W-1:0]  dx;
    logic [DB_W-1:0] db;
    logic [R_W-1:0]  r;
    logic            f;
    logic [C_W-1:0]  c;
  } esp_seg6_t;

  typedef struct packed {
    logic            v;
    logic            width_under_four;
    logic            m;
    logic [X_W-1:0]  dx;
    logic [NF_W-1:0] n;
    logic [GO_W-1:0] g;
    logic [DB_W-1:0] db;
    logic            f;
    logic [C_W-1:0]  c;
  } esp_seg7_t;

  typedef struct packed {
    logic            single;
    logic            left_dx0;
    logic [DB_W-1:0] left_db;
    logic [C_W-1:0]  left_c;
    logic [X_W-1:0]  right_dx;
    logic [NF_W-1:0] right_n;
    logic [GO_W-1:0] right_g;
    logic            right_f;
    logic [C_W-1:0]  right_c;
    logic            right_m;
  } esp_word_t;

  typedef struct packed {
    logic [19:0] zero;
    logic        hold;
    logic        started;
    logic        full;
    logic [8:0]  count;
  } esp_status_t;

endpackage

// ### core/esp_decoder.sv
`timescale 1ns/100ps

// Notes on behaviour
// - eight pipeline levels from edge bus to one segment-buffer word
// - pipeline advances only on 150 ns ticks (134 ns rounded up to six clocks) qualified by advance enable
// - a left segment of width three or less pairs with the next one
// - each word has a pair flag, zero meaning two segments present
// - paired left segment: width low bit, 8-bit brightness step, colour
// - right segment: width, zero count, gradient, shading, colour, marker
// - first-word marker set in the word holding a scanline's first segment
// - write strobe enable raised when segment data are ready to store and the buffer is not full or the word carries the first-word marker
// - intercept math split over levels one and two; scale kept in level one
// - level two yields valid, colour, shading, rounded x and b intercepts
// - segment right of the last valid edge gets the maximum width
// - level three buffers; level four forms width and brightness step
// - width borrow takes one from the next width until absorbed
// - widths below two become two and raise width borrow
// - level five outputs width, step, reciprocal, flags, narrow and more
// - brightness step carried as magnitude plus sign
// - unshaded reciprocal is 2^18 over normalised half width, at most 512
// - shaded segments use reciprocal 2^9
// - reciprocal from 256 by 11-bit table: mantissa and three corrections
// - normalised half width: top eight bits index, low two pick corrections
module esp_decoder
  import esp_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              pipe_advance_enable,
  input  wire logic              load_cycle_reset,
  input  wire esp_edge_t         edge_in,
  input  wire logic [TA_W-1:0]   table_address,
  input  wire logic [TBL_W-1:0]  table_write_data,
  input  wire logic              table_select,
  input  wire logic              table_write_pulse,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  output logic                   buffer_write_strobe_enable,
  output esp_word_t              seg_word
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // leading zeros of an 11-bit width, stopped at the cap
  function automatic logic [N_W-1:0] lead_zeros(input logic [X_W-1:0] w);
    logic [N_W-1:0] n;
    logic           hit;
    n   = '0;
    hit = 1'b0;
    for (int i = X_W - 1; i >= 0; i--) begin
      if (!hit && !w[i] && n < LZ_CAP) begin
        n = n + 1'b1;
      end else begin
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pipe tick and advance

  logic [TICK_CW-1:0] tick_cnt;
  logic               adv;

  // free-running divider giving one tick per pipe period
  always_ff @(posedge clk_sys) begin
    if (rst || tick_cnt == TICK_LAST) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // enable gating is the controller's job; we only obey it
  // flushing relies on the controller holding enable high
  assign adv = (tick_cnt == TICK_LAST) && pipe_advance_enable;

  ////////////////////////////////////////////////////////////////////////
  // levels one to four

  esp_lvl1_t s1;
  esp_lvl2_t s2;
  esp_icpt_t s3;
  esp_icpt_t s4;
  esp_icpt_t next_s3;
  logic signed [PX_W-1:0] xr;
  logic signed [PB_W-1:0] br;

  // level one keeps dy scaled by 2^m, not dy and m apart
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= '0;
    end else if (adv) begin
      s1.v     <= edge_in.v;
      s1.c     <= edge_in.c;
      s1.f     <= edge_in.f;
      s1.x     <= edge_in.x;
      s1.b     <= edge_in.b;
      s1.s     <= edge_in.s;
      s1.g     <= edge_in.g;
      s1.scale <= SCALE_W'(edge_in.dy) << edge_in.m;
    end
  end

  // products split off so the add and round fit in level two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s2 <= '0;
    end else if (adv) begin
      s2.v  <= s1.v;
      s2.c  <= s1.c;
      s2.f  <= s1.f;
      s2.x  <= s1.x;
      s2.b  <= s1.b;
      s2.px <= $signed({1'b0, s1.scale}) * s1.s;
      s2.pb <= $signed({1'b0, s1.scale}) * s1.g;
    end
  end

  // intercepts: product times 2^-11, rounded, plus base
  always_comb begin
    xr        = (s2.px + $signed(PX_W'(ROUND_HALF))) >>> FRAC;
    br        = (s2.pb + $signed(PB_W'(ROUND_HALF))) >>> FRAC;
    next_s3.v = s2.v;
    next_s3.c = s2.c;
    next_s3.f = s2.f;
    next_s3.x = s2.x + xr[X_W-1:0];
    next_s3.b = s2.b + br[B_W-1:0];
  end

  // levels three and four are plain buffers of edge intercepts
  // level three holds the next edge, level four this edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s3 <= '0;
      s4 <= '0;
    end else if (adv) begin
      s3 <= next_s3;
      s4 <= s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // level four arithmetic and level five

  esp_seg5_t       s5;
  esp_seg5_t       next_s5;
  logic            width_borrow;
  logic [DB_W-1:0] db_diff;
  logic [DB_W-1:0] db_mag;
  logic            s5_small;

  // widths below two are found by a signed compare of the 12-bit width with two
  assign s5_small = $signed(s5.dx) < $signed({1'b0, WIDTH_MIN});

  // borrow from the segment now in level five
  assign width_borrow = s5.v && s5_small;

  // width and brightness step of the segment right of this edge
  always_comb begin
    db_diff        = {1'b0, s3.b} - {1'b0, s4.b};
    next_s5.v      = s4.v;
    next_s5.valid_and_more_follow    = s4.v && s3.v;
    next_s5.f      = s4.f;
    next_s5.c      = s4.c;
    // borrow trims the following width by one
    next_s5.dx     = {1'b0, s3.x} - {1'b0, s4.x} - (X_W + 1)'(width_borrow);
    db_mag         = db_diff[DB_W-1] ? DB_W'(-db_diff) : db_diff;
    next_s5.db     = {db_diff[DB_W-1], db_mag[DB_W-2:0]};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s5 <= '0;
    end else if (adv) begin
      s5 <= next_s5;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reciprocal table and level five outputs

  logic [TBL_W-1:0] tbl [TBL_DEPTH];
  logic [X_W-1:0]   dx5;
  logic [N_W-1:0]   nz5;
  logic [9:0]       half_w;
  logic [9:0]       norm;
  logic [TBL_W-1:0] entry;
  logic [R_W-1:0]   r_base;
  logic [R_W-1:0]   r_corr;
  esp_seg6_t        next_s6;

  // table load from the terminal control side
  // table kept as a writable array; contents survive reset
  always_ff @(posedge clk_sys) begin
    if (table_select && table_write_pulse) begin
      tbl[table_address] <= table_write_data;
    end
  end

  // clamp to a minimum width of two
  assign dx5 = s5_small ? WIDTH_MIN : s5.dx[X_W-1:0];

  always_comb begin
    nz5    = lead_zeros(dx5);
    half_w = dx5[X_W-1:1];
    // normalise the half width, then index by the top eight bits
    norm   = half_w << nz5;
    entry  = tbl[norm[9:2]];
    // stored mantissa has an implied leading one at bit eight
    r_base = {2'b01, entry[7:0]};
    // low two bits pick how many correction bits to add, plus one
    unique case (norm[1:0])
      2'b11:   r_corr = R_W'(1);
      2'b10:   r_corr = R_W'(1) + R_W'(entry[8]);
      2'b01:   r_corr = R_W'(1) + R_W'(entry[8]) + R_W'(entry[9]);
      default: r_corr = R_W'(1) + R_W'(entry[8]) + R_W'(entry[9])
                        + R_W'(entry[10]);
    endcase
    next_s6.v   = s5.v;
    next_s6.valid_and_more_follow = s5.valid_and_more_follow;
    next_s6.width_under_four = dx5 < WIDTH_NARROW;
    next_s6.dx  = dx5;
    next_s6.db  = s5.db;
    next_s6.f   = s5.f;
    next_s6.c   = s5.c;
    // unshaded reciprocal from the corrected table value
    next_s6.r   = s5.f ? R_SHADED : r_base + r_corr;
  end

  ////////////////////////////////////////////////////////////////////////
  // level six: last-width force, gradient product, first marker

  esp_seg6_t       s6;
  esp_seg7_t       next_s7;
  logic            prev_v6;
  logic            last_seg;
  logic [X_W-1:0]  width_max;
  logic [GP_W-1:0] gprod;
  logic [N_W-1:0]  nz6;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s6      <= '0;
      prev_v6 <= 1'b0;
    end else if (adv) begin
      s6      <= next_s6;
      prev_v6 <= s6.v;
    end
  end

  assign last_seg = s6.v && !s6.valid_and_more_follow;

  always_comb begin
    // stretch the last segment to the right boundary
    next_s7.dx  = last_seg ? width_max : s6.dx;
    next_s7.width_under_four = last_seg ? 1'b0 : s6.width_under_four;
    nz6         = lead_zeros(next_s7.dx);
    // field is three bits wide, so counts above seven saturate
    next_s7.n   = (nz6 > N_W'(NF_CAP)) ? NF_CAP : nz6[NF_W-1:0];
    // gradient = step times reciprocal over 128, rounded
    gprod       = GP_W'(s6.db[DB_W-2:0]) * GP_W'(s6.r) + G_HALF;
    next_s7.g   = {s6.db[DB_W-1], gprod[G_SHIFT +: GO_W-1]};
    next_s7.v   = s6.v;
    // first valid after an invalid one starts the scanline
    next_s7.m   = s6.v && !prev_v6;
    next_s7.db  = s6.db;
    next_s7.f   = s6.f;
    next_s7.c   = s6.c;
  end

  ////////////////////////////////////////////////////////////////////////
  // levels seven and eight: pairing and word assembly

  esp_seg7_t   s7;
  esp_seg7_t   s8;
  logic        s8_hold;
  logic        next_hold;
  esp_seg7_t   next_s8;
  esp_word_t   next_word;
  logic        want_wr;
  logic        do_write;
  logic        started;
  logic        full;
  logic [8:0]  count;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s7 <= '0;
    end else if (adv) begin
      s7 <= next_s7;
    end
  end

  always_comb begin
    next_word = '0;
    next_hold = s8_hold;
    next_s8   = s8;
    want_wr   = 1'b0;
    // right segment fields come from level seven
    next_word.single   = 1'b1;
    next_word.right_dx = s7.dx;
    next_word.right_n  = s7.n;
    next_word.right_g  = s7.g;
    next_word.right_f  = s7.f;
    next_word.right_c  = s7.c;
    next_word.right_m  = s7.m;
    if (s7.v && !s8_hold && s7.width_under_four) begin
      // narrow left segment waits in level eight for its partner
      next_hold = 1'b1;
      next_s8   = s7;
    end else if (s8_hold) begin
      // narrow left needs only width bit zero, step and colour
      next_word.single   = 1'b0;
      next_word.left_dx0 = s8.dx[0];
      next_word.left_db  = s8.db;
      next_word.left_c   = s8.c;
      // marker of a waiting first segment moves into the pair
      next_word.right_m  = s8.m || (s7.v && s7.m);
      if (!s7.v) begin
        next_word.right_dx = '0;
        next_word.right_n  = '0;
        next_word.right_g  = '0;
        next_word.right_f  = 1'b0;
        next_word.right_c  = '0;
      end
      next_hold = 1'b0;
      want_wr   = 1'b1;
    end else if (s7.v) begin
      want_wr = 1'b1;
    end else if (started) begin
      // trailing nulls push the line data forward in the buffer
      next_word = '0;
      next_word.single = 1'b1;
      want_wr   = 1'b1;
    end
  end

  // a word is stored only on an advance, once, while room remains or when it carries the first-word marker
  assign do_write = adv && want_wr && (!full || next_word.right_m);
  assign full     = count >= BUF_WORDS;

  // pairing state moves with the pipe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s8      <= '0;
      s8_hold <= 1'b0;
    end else if (adv) begin
      s8      <= next_s8;
      s8_hold <= next_hold;
    end
  end

  // load cycle reset leaves the counter full until a first word
  always_ff @(posedge clk_sys) begin
    if (rst || load_cycle_reset) begin
      count   <= BUF_WORDS;
      started <= 1'b0;
    end else if (do_write) begin
      count   <= next_word.right_m ? CNT_FIRST : count + 1'b1;
      started <= started || next_word.right_m;
    end
  end

  // strobe leaves from a flip-flop for one cycle; the word is held until the next store
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buffer_write_strobe_enable <= 1'b0;
      seg_word                   <= '0;
    end else begin
      buffer_write_strobe_enable <= do_write;
      if (do_write) begin
        seg_word <= next_word;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port

  esp_status_t status;

  always_comb begin
    status         = '0;
    status.hold    = s8_hold;
    status.started = started;
    status.full    = full;
    status.count   = count;
  end

  // width used for the last segment of a line
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      width_max <= WIDTH_MAX_RST;
    end else if (reg_wr && reg_addr == ADDR_WIDTH_MAX) begin
      width_max <= reg_wdata[X_W-1:0];
    end
  end

  // read data valid only in the cycle after the strobe; unmapped read zero
  always_ff @(posedge clk_sys) begin
    if (rst || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == ADDR_WIDTH_MAX) begin
      reg_rdata <= 32'(width_max);
    end else if (reg_addr == ADDR_STATUS) begin
      reg_rdata <= status;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// ### testbench/esp_decoder_sva.sv
`timescale 1ns/100ps

module esp_decoder_sva
  import esp_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              pipe_advance_enable,
  input wire logic              load_cycle_reset,
  input wire esp_edge_t         edge_in,
  input wire logic [TA_W-1:0]   table_address,
  input wire logic [TBL_W-1:0]  table_write_data,
  input wire logic              table_select,
  input wire logic              table_write_pulse,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              buffer_write_strobe_enable,
  input wire esp_word_t         seg_word
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // leading zeros of a width, saturated at the field's top value
  function automatic logic [NF_W-1:0] zero_run(input logic [X_W-1:0] d);
    int k;
    k = 0;
    while (k < 7 && !d[X_W-1-k]) k++;
    return NF_W'(k);
  endfunction

  // a stored word must leave the rest of its pipe tick quiet
  sequence s_quiet;
    !buffer_write_strobe_enable [*5];
  endsequence

  AST_STROBE_SPACING: assert property (
    buffer_write_strobe_enable |=> s_quiet)
    else $error("write strobe repeated inside one pipe tick");
  AST_STROBE_AFTER_ADV: assert property (
    buffer_write_strobe_enable |-> $past(pipe_advance_enable))
    else $error("word stored without an advancing tick");
  AST_WORD_HOLD: assert property (
    !buffer_write_strobe_enable |-> $stable(seg_word))
    else $error("segment word changed without a strobe");
  AST_MIN_WIDTH: assert property (
    seg_word.right_dx != 11'h000 |-> seg_word.right_dx >= WIDTH_MIN)
    else $error("stored width below the minimum");
  AST_ZERO_COUNT: assert property (
    seg_word.right_dx != 11'h000 |->
      seg_word.right_n == zero_run(seg_word.right_dx))
    else $error("zero count does not match stored width");
  AST_RDATA_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  AST_STATUS_TOP: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_STATUS |->
      reg_rdata[31:12] == 20'h00000)
    else $error("status upper bits not zero");
  AST_WIDTH_TOP: assert property (
    $past(reg_rd) && $past(reg_addr) == ADDR_WIDTH_MAX |->
      reg_rdata[31:11] == 21'h000000)
    else $error("width limit upper bits not zero");
endmodule

bind esp_decoder esp_decoder_sva chk_u (
  .clk_sys(clk_sys), .rst(rst), .pipe_advance_enable(pipe_advance_enable),
  .load_cycle_reset(load_cycle_reset), .edge_in(edge_in),
  .table_address(table_address), .table_write_data(table_write_data),
  .table_select(table_select), .table_write_pulse(table_write_pulse),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seg_word(seg_word),
  .buffer_write_strobe_enable(buffer_write_strobe_enable)
);

// ### testbench/esp_edge_source.sv
`timescale 1ns/100ps

module esp_edge_source
  import esp_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  output esp_edge_t edge_out,
  output logic      adv_en
);
  esp_edge_t   q_edge[$];
  logic        q_en[$];
  logic [2:0]  phase;

  task automatic push(input esp_edge_t e, input logic en);
    q_edge.push_back(e);
    q_en.push_back(en);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one bus slot per pipe tick; phase mirrors the tick divider after reset
  always @(posedge clk_sys) begin
    if (rst) begin
      phase    <= 3'h0;
      edge_out <= '0;
      adv_en   <= 1'b1;
    end else begin
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      if (phase == 3'h5) begin
        if (q_edge.size() > 0) begin
          edge_out <= q_edge.pop_front();
          adv_en   <= q_en.pop_front();
        end else begin
          // flush every tick; an all-zero edge keeps the tail known
          edge_out <= '0;
          adv_en   <= 1'b1;
        end
      end
    end
  end
endmodule

// ### testbench/test_edge_to_segment_pipeline.sv
`timescale 1ns/100ps

module test_edge_to_segment_pipeline
  import esp_pkg::*;
;
  localparam int P18 = 1 << 18;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              load_cycle_reset = 1'b0;
  logic [TA_W-1:0]   table_address = '0;
  logic [TBL_W-1:0]  table_write_data = '0;
  logic              table_select = 1'b0;
  logic              table_write_pulse = 1'b0;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [31:0]       reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [31:0]       reg_rdata;
  logic              buffer_write_strobe_enable;
  esp_word_t         seg_word;
  esp_edge_t         edge_in;
  logic              pipe_advance_enable;
  int                err_count = 0;
  int                tests_run = 0;
  esp_word_t         words[$];
  logic [31:0]       rd;

  always #12.5 clk_sys = ~clk_sys;

  esp_edge_source src_u (.clk_sys(clk_sys), .rst(rst), .edge_out(edge_in),
    .adv_en(pipe_advance_enable));

  esp_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .edge_in(edge_in),
    .pipe_advance_enable(pipe_advance_enable),
    .load_cycle_reset(load_cycle_reset), .table_address(table_address),
    .table_write_data(table_write_data), .table_select(table_select),
    .table_write_pulse(table_write_pulse), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seg_word(seg_word),
    .buffer_write_strobe_enable(buffer_write_strobe_enable));

  // capture every stored word in order
  always @(posedge clk_sys) begin
    if (buffer_write_strobe_enable === 1'b1) begin
      words.push_back(seg_word);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // expected reciprocal, table entry and gradient worked out independently
  function automatic int recip(input int dx);
    int n;
    n = 0;
    while (n < 9 && dx < (1 << (10 - n))) n++;
    return P18 / ((dx >> 1) << n);
  endfunction

  function automatic logic [TBL_W-1:0] tword(input int k);
    int a;
    a = 4 * k;
    return {1'(P18 / a - P18 / (a + 1)), 1'(P18 / (a + 1) - P18 / (a + 2)),
            1'(P18 / (a + 2) - P18 / (a + 3)), 8'(P18 / (a + 3) - 257)};
  endfunction

  function automatic logic [8:0] grad(input int mag, input int r);
    return 9'((mag * r + 64) >> 7);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_word(input string what, input esp_word_t exp,
                            input esp_word_t got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // single-segment word: left half zero, shaded right segment
  task automatic check_single(input int i, input logic [X_W-1:0] dx,
    input logic [NF_W-1:0] n, input logic [GO_W-1:0] g,
    input logic [C_W-1:0] c, input logic m);
    esp_word_t e;
    e = '0;
    e.single = 1'b1;
    e.right_dx = dx;
    e.right_n = n;
    e.right_g = g;
    e.right_f = 1'b1;
    e.right_c = c;
    e.right_m = m;
    check_word("single word", e, words[i]);
  endtask

  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic table_write(input int k, input logic [TBL_W-1:0] d);
    @(posedge clk_sys);
    table_select      <= 1'b1;
    table_write_pulse <= 1'b1;
    table_address     <= TA_W'(k);
    table_write_data  <= d;
    @(posedge clk_sys);
    table_select      <= 1'b0;
    table_write_pulse <= 1'b0;
  endtask

  task automatic send(input int x, input int b, input logic [C_W-1:0] c,
                      input logic f, input int dy);
    src_u.push(esp_edge_t'{v: 1'b1, dy: DY_W'(dy), m: 4'hB, x: X_W'(x),
      s: 13'sh0005, b: B_W'(b), g: 10'sh002, c: c, f: f}, 1'b1);
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 4000 && words.size() < n; i++) @(posedge clk_sys);
    // a stalled pipe counts as a mismatch
    if (words.size() < n) err_count++;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch; the run needs well under this span
  initial begin
    #(25 * 20000);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    reg_read(ADDR_WIDTH_MAX, rd);
    check_val("width limit reset", 32'h000007FF, rd);
    reg_write(8'h08, 32'hFFFFFFFF);
    reg_read(8'h08, rd);
    check_val("unmapped read", 32'h00000000, rd);
    reg_read(ADDR_WIDTH_MAX, rd);
    check_val("width limit kept", 32'h000007FF, rd);
    table_write(196, tword(196));
    // one block: narrow pair, stalled slot, borrow, unshaded, last edge
    send(11'h064, 7'h0A, 12'hA00, 1'b1, 0);
    src_u.push(esp_edge_t'{v: 1'b0, default: '1}, 1'b0);
    send(11'h066, 7'h14, 12'hA01, 1'b0, 0);
    send(11'h0C3, 7'h0A, 12'hA02, 1'b1, 1);
    send(11'h0C9, 7'h0F, 12'hA03, 1'b1, 0);
    send(11'h0FA, 7'h1E, 12'hA04, 1'b1, 0);
    wait_words(256);
    repeat (60) @(posedge clk_sys);
    check_val("word count", 32'h00000100, 32'(words.size()));
    check_word("pair first", '{single: 1'b0, left_dx0: 1'b0,
      left_db: 8'h0A, left_c: 12'hA00, right_dx: 11'h062, right_n: 3'h4,
      right_g: {1'b1, grad(8, recip(98))}, right_f: 1'b0,
      right_c: 12'hA01, right_m: 1'b1}, words[0]);
    check_word("pair borrow", '{single: 1'b0, left_dx0: 1'b0,
      left_db: 8'h03, left_c: 12'hA02, right_dx: 11'h030, right_n: 3'h5,
      right_g: {1'b0, grad(15, 512)}, right_f: 1'b1,
      right_c: 12'hA03, right_m: 1'b0}, words[1]);
    check_single(2, WIDTH_MAX_RST, 3'h0, {1'b1, grad(30, 512)},
      12'hA04, 1'b0);
    check_word("null word", '{single: 1'b1, default: '0}, words[3]);
    reg_read(ADDR_STATUS, rd);
    check_val("full and started", 32'h00000003, 32'(rd[10:9]));
    // end of load cycle, new width limit, one lone edge
    @(posedge clk_sys);
    load_cycle_reset <= 1'b1;
    @(posedge clk_sys);
    load_cycle_reset <= 1'b0;
    reg_read(ADDR_STATUS, rd);
    check_val("started cleared", 32'h00000000, 32'(rd[10]));
    reg_write(ADDR_WIDTH_MAX, 32'h00000123);
    send(11'h1F4, 7'h05, 12'hA05, 1'b1, 0);
    wait_words(257);
    check_single(256, 11'h123, 3'h2, {1'b1, grad(5, 512)},
      12'hA05, 1'b1);
    complete_run();
  end
endmodule
